// file: src/hri_pkg.sv
// package for the host register window and interrupt port
package hri_pkg;
    // direct register byte offsets, selected by address bits 5..2
    localparam logic [5:0] OFF_QUEUE0 = 6'h00;
    localparam logic [5:0] OFF_QUEUE1 = 6'h04;
    localparam logic [5:0] OFF_QUEUE2 = 6'h08;
    localparam logic [5:0] OFF_QUEUE3 = 6'h0C;
    localparam logic [5:0] OFF_HRQ0 = 6'h18;
    localparam logic [5:0] OFF_HRQ1 = 6'h1C;
    localparam logic [5:0] OFF_QUEUE_FLAGS = 6'h20;
    localparam logic [5:0] OFF_TIMER_FLAGS = 6'h24;
    localparam logic [5:0] OFF_IO_FLAGS = 6'h28;
    localparam logic [5:0] OFF_COMBINED = 6'h2C;
    localparam logic [5:0] OFF_IND_INDEX = 6'h30;
    localparam logic [5:0] OFF_IND_DATA = 6'h34;
    localparam logic [5:0] OFF_TXQ0_DONE = 6'h38;
    localparam logic [5:0] OFF_TXQ1_DONE = 6'h3C;

    // reset values
    localparam logic [15:0] RST_QUEUE_FLAGS = 16'h0F00;
    localparam logic [15:0] RST_TIMER_FLAGS = 16'h0000;
    localparam logic [15:0] RST_IO_FLAGS = 16'h0000;
    localparam logic [15:0] RST_IND_INDEX = 16'h0000;
    localparam logic [15:0] RST_DONE_COUNT = 16'h0000;
    localparam logic [31:0] RST_HEAD = 32'h0000_0000;

    // indirect space: event routing words sit in flops at these indices
    localparam int NUM_LINES = 3;
    localparam int NUM_SOURCES = 3;
    localparam logic [15:0] IND_MAP_BASE = 16'h0000;
    localparam logic [15:0] IND_MAP_LAST = 16'h0008;
    localparam int IND_MEM_AW = 8;

    // combined flag bit positions
    localparam int CMB_QUEUE_BIT = 0;
    localparam int CMB_TIMER_BIT = 1;
    localparam int CMB_IO_BIT = 2;

    // indices of sources within a routing group
    localparam int SRC_QUEUE = 0;
    localparam int SRC_TIMER = 1;
    localparam int SRC_IO = 2;

    // one routing word per line per source
    typedef logic [NUM_LINES-1:0][NUM_SOURCES-1:0][15:0] hri_map_t;

    // event set strobes from the switch core
    typedef struct packed {
        logic [15:0] queue_set;
        logic [15:0] timer_set;
        logic [15:0] io_set;
        logic [1:0] txq_done;
    } hri_events_t;

    // complete state of the top module
    typedef struct packed {
        logic strap_done;
        logic mux_mode;
        logic [3:0] latched_addr;
        logic [31:0] rdata;
        logic [31:0] txq_data;
        logic [3:0] txq_push;
        logic [3:0] rxq_pop;
        logic [1:0] hrq_pop;
        logic [31:0] head0;
        logic [31:0] head1;
        logic [15:0] queue_flags;
        logic [15:0] timer_flags;
        logic [15:0] io_flags;
        logic [15:0] ind_index;
        hri_map_t route;
        logic [15:0] done0;
        logic [15:0] done1;
        logic [2:0] irq;
    } hri_state_t;
endpackage : hri_pkg

// file: src/hri_ind_mem.sv
// indirect register storage with registered read data
`timescale 1ns/1ps
module hri_ind_mem (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [hri_pkg::IND_MEM_AW-1:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [15:0] mem [0:(1 << hri_pkg::IND_MEM_AW)-1];

    // read every cycle so the word for the current index is ready one cycle after the index or the word changes
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : hri_ind_mem

// file: src/hri_top.sv
// host register window with routed level interrupt lines
// Summary of operation
// RULE1 - four address bits select sixteen direct registers
// RULE2 - index at 0x30, data port at 0x34
// RULE3 - queue offsets: read receives, write transmits
// RULE4 - host queue read data; writes load head
// RULE5 - completion counters read-only sixteen bit, reset zero
// RULE6 - indirect port reads and writes selected register
// RULE7 - exactly three interrupt lines from status events
// RULE8 - any event routable to any line
// RULE9 - line high until host clears status
// RULE10 - line is OR of all routed sources
// RULE11 - lines identical, no priority among them
// RULE12 - host wires each line to own input
// RULE13 - host gives high line top priority
// RULE14 - three status registers RW, combined read-only
// RULE15 - word aligned, address bits five to two
// RULE16 - indirect data only on low sixteen bits
// RULE17 - strap selects multiplexed or separate address
// RULE18 - reserved offsets read zero, writes ignored
`timescale 1ns/1ps
module hri_top (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic BUS_MUX_SELECT,
    input wire logic HOST_ALE,
    input wire logic [3:0] HOST_ADDR,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic [31:0] HOST_WDATA,
    output logic [31:0] HOST_RDATA,
    input wire logic [3:0][31:0] RXQ_DATA,
    output logic [3:0] RXQ_POP,
    output logic [31:0] TXQ_DATA,
    output logic [3:0] TXQ_PUSH,
    input wire logic [1:0][31:0] HRQ_DATA,
    output logic [1:0] HRQ_POP,
    output logic [31:0] HRQ0_HEAD,
    output logic [31:0] HRQ1_HEAD,
    input wire hri_pkg::hri_events_t EVENTS,
    output logic MUX_MODE,
    output logic IRQ_LINE_LOW,
    output logic IRQ_LINE_MID,
    output logic IRQ_LINE_HIGH
);
    hri_pkg::hri_state_t st_r;
    hri_pkg::hri_state_t st_nxt;
    logic [3:0] sel;
    logic [5:0] off;
    logic ind_map_hit;
    logic [3:0] map_pos;
    logic mem_wr;
    logic [15:0] mem_rdata;

    // true when any flag bit is enabled by its routing word
    function automatic logic routed(input logic [15:0] flags, input logic [15:0] enables);
        routed = |(flags & enables);
    endfunction : routed

    // hardware sets win over a same-cycle host clear (write one to clear)
    function automatic logic [15:0] flag_update(input logic [15:0] cur, input logic [15:0] set,
                                                input logic clr_en, input logic [15:0] clr);
        flag_update = (cur & ~(clr_en ? clr : 16'h0000)) | set;
    endfunction : flag_update

    // register select: latched address in multiplexed mode, pins otherwise
    assign sel = st_r.mux_mode ? st_r.latched_addr : HOST_ADDR; // [RULE17]
    assign off = {sel, 2'b00}; // [RULE15]
    assign ind_map_hit = st_r.ind_index <= hri_pkg::IND_MAP_LAST;
    assign map_pos = st_r.ind_index[3:0];
    assign mem_wr = HOST_WR && (off == hri_pkg::OFF_IND_DATA) && !ind_map_hit; // [RULE6]

    hri_ind_mem u_mem (
        .clk(CLK),
        .wr_en(mem_wr),
        .addr(st_r.ind_index[hri_pkg::IND_MEM_AW-1:0]),
        .wdata(HOST_WDATA[15:0]),
        .rdata(mem_rdata)
    );

    // next-state logic for the whole register window
    always_comb begin
        logic [15:0] q_clr;
        logic [15:0] t_clr;
        logic [15:0] io_clr;
        logic q_wr;
        logic t_wr;
        logic io_wr;
        logic [15:0] cmb;
        logic [15:0] ind_rd;
        q_clr = HOST_WDATA[15:0];
        t_clr = HOST_WDATA[15:0];
        io_clr = HOST_WDATA[15:0];
        q_wr = HOST_WR && (off == hri_pkg::OFF_QUEUE_FLAGS); // [RULE14]
        t_wr = HOST_WR && (off == hri_pkg::OFF_TIMER_FLAGS); // [RULE14]
        io_wr = HOST_WR && (off == hri_pkg::OFF_IO_FLAGS); // [RULE14]
        cmb = 16'h0000;
        cmb[hri_pkg::CMB_QUEUE_BIT] = |st_r.queue_flags;
        cmb[hri_pkg::CMB_TIMER_BIT] = |st_r.timer_flags;
        cmb[hri_pkg::CMB_IO_BIT] = |st_r.io_flags;
        ind_rd = ind_map_hit ? st_r.route[map_pos / 4'h3][map_pos % 4'h3] : mem_rdata;
        st_nxt = st_r;
        st_nxt.txq_push = 4'h0;
        st_nxt.rxq_pop = 4'h0;
        st_nxt.hrq_pop = 2'h0;

        // bus mode strap is caught once, on the first edge after reset
        if (!st_r.strap_done) begin
            st_nxt.strap_done = 1'b1;
            st_nxt.mux_mode = BUS_MUX_SELECT; // [RULE17]
        end
        // in multiplexed mode the word address rides on the data lines
        if (HOST_ALE) begin
            st_nxt.latched_addr = HOST_WDATA[5:2]; // [RULE17]
        end

        // read path: selected content is registered onto the data bus
        if (HOST_RD) begin
            case (off) // [RULE1]
                hri_pkg::OFF_QUEUE0, hri_pkg::OFF_QUEUE1, hri_pkg::OFF_QUEUE2, hri_pkg::OFF_QUEUE3: begin
                    st_nxt.rdata = RXQ_DATA[sel[1:0]]; // [RULE3]
                    st_nxt.rxq_pop[sel[1:0]] = 1'b1;
                end
                hri_pkg::OFF_HRQ0: begin
                    st_nxt.rdata = HRQ_DATA[0]; // [RULE4]
                    st_nxt.hrq_pop[0] = 1'b1;
                end
                hri_pkg::OFF_HRQ1: begin
                    st_nxt.rdata = HRQ_DATA[1]; // [RULE4]
                    st_nxt.hrq_pop[1] = 1'b1;
                end
                hri_pkg::OFF_QUEUE_FLAGS: st_nxt.rdata = {16'h0000, st_r.queue_flags};
                hri_pkg::OFF_TIMER_FLAGS: st_nxt.rdata = {16'h0000, st_r.timer_flags};
                hri_pkg::OFF_IO_FLAGS: st_nxt.rdata = {16'h0000, st_r.io_flags};
                hri_pkg::OFF_COMBINED: st_nxt.rdata = {16'h0000, cmb}; // [RULE14]
                hri_pkg::OFF_IND_INDEX: st_nxt.rdata = {16'h0000, st_r.ind_index}; // [RULE2]
                hri_pkg::OFF_IND_DATA: st_nxt.rdata = {16'h0000, ind_rd}; // [RULE6] [RULE16]
                hri_pkg::OFF_TXQ0_DONE: st_nxt.rdata = {16'h0000, st_r.done0}; // [RULE5]
                hri_pkg::OFF_TXQ1_DONE: st_nxt.rdata = {16'h0000, st_r.done1}; // [RULE5]
                default: st_nxt.rdata = 32'h0000_0000; // [RULE18]
            endcase
        end

        // write path: read-only and reserved offsets fall to default
        if (HOST_WR) begin
            case (off) // [RULE1]
                hri_pkg::OFF_QUEUE0, hri_pkg::OFF_QUEUE1, hri_pkg::OFF_QUEUE2, hri_pkg::OFF_QUEUE3: begin
                    st_nxt.txq_data = HOST_WDATA; // [RULE3]
                    st_nxt.txq_push[sel[1:0]] = 1'b1;
                end
                hri_pkg::OFF_HRQ0: st_nxt.head0 = HOST_WDATA; // [RULE4]
                hri_pkg::OFF_HRQ1: st_nxt.head1 = HOST_WDATA; // [RULE4]
                hri_pkg::OFF_IND_INDEX: st_nxt.ind_index = HOST_WDATA[15:0]; // [RULE2]
                hri_pkg::OFF_IND_DATA: begin
                    // routing words live in flops so they feed the lines directly
                    if (ind_map_hit) begin
                        st_nxt.route[map_pos / 4'h3][map_pos % 4'h3] = HOST_WDATA[15:0]; // [RULE8] [RULE16]
                    end
                end
                default: st_nxt.rdata = st_nxt.rdata; // [RULE18]
            endcase
        end

        // sticky event flags, set wins over clear
        st_nxt.queue_flags = flag_update(st_r.queue_flags, EVENTS.queue_set, q_wr, q_clr); // [RULE9]
        st_nxt.timer_flags = flag_update(st_r.timer_flags, EVENTS.timer_set, t_wr, t_clr); // [RULE9]
        st_nxt.io_flags = flag_update(st_r.io_flags, EVENTS.io_set, io_wr, io_clr); // [RULE9]

        // completion counters wrap; the core owns them, the host only reads
        if (EVENTS.txq_done[0]) begin
            st_nxt.done0 = st_r.done0 + 16'h0001; // [RULE5]
        end
        if (EVENTS.txq_done[1]) begin
            st_nxt.done1 = st_r.done1 + 16'h0001; // [RULE5]
        end

        // each line ORs its routed sources; all three built the same way
        for (int k = 0; k < hri_pkg::NUM_LINES; k++) begin // [RULE7] [RULE11]
            st_nxt.irq[k] = routed(st_r.queue_flags, st_r.route[k][hri_pkg::SRC_QUEUE])
                          | routed(st_r.timer_flags, st_r.route[k][hri_pkg::SRC_TIMER])
                          | routed(st_r.io_flags, st_r.route[k][hri_pkg::SRC_IO]); // [RULE10] [RULE8]
        end
    end

    // state register; routing starts cleared so reset flags stay quiet
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_r <= '0;
            st_r.queue_flags <= hri_pkg::RST_QUEUE_FLAGS;
            st_r.timer_flags <= hri_pkg::RST_TIMER_FLAGS;
            st_r.io_flags <= hri_pkg::RST_IO_FLAGS;
            st_r.ind_index <= hri_pkg::RST_IND_INDEX;
            st_r.head0 <= hri_pkg::RST_HEAD;
            st_r.head1 <= hri_pkg::RST_HEAD;
            st_r.done0 <= hri_pkg::RST_DONE_COUNT; // [RULE5]
            st_r.done1 <= hri_pkg::RST_DONE_COUNT; // [RULE5]
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs all come straight from state flops
    assign HOST_RDATA = st_r.rdata;
    assign RXQ_POP = st_r.rxq_pop;
    assign TXQ_DATA = st_r.txq_data;
    assign TXQ_PUSH = st_r.txq_push;
    assign HRQ_POP = st_r.hrq_pop;
    assign HRQ0_HEAD = st_r.head0;
    assign HRQ1_HEAD = st_r.head1;
    assign MUX_MODE = st_r.mux_mode;
    assign IRQ_LINE_LOW = st_r.irq[0];
    assign IRQ_LINE_MID = st_r.irq[1];
    assign IRQ_LINE_HIGH = st_r.irq[2];
endmodule : hri_top

// file: sim/hri_core_model.sv
// core-side queue model feeding receive and host queue words
`timescale 1ns/1ps
module hri_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] pop,
    output logic [3:0][31:0] rxq_data,
    output logic [1:0][31:0] hrq_data
);
    logic [5:0][15:0] cnt_r;
    // each pop moves its queue on to the next word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (pop[i]) begin
                    cnt_r[i] <= cnt_r[i] + 16'h0001;
                end
            end
        end
    end
    // queue number in the word so a wrong queue select shows up
    always_comb begin
        for (int i = 0; i < 4; i++) rxq_data[i] = {8'h5A, 4'h0, 4'(i), cnt_r[i]};
        for (int i = 0; i < 2; i++) hrq_data[i] = {8'h5A, 4'h0, 4'(i + 4), cnt_r[i + 4]};
    end
endmodule : hri_core_model

// file: sim/hri_top_sva.sv
// port assertions for the host register window
`timescale 1ns/1ps
module hri_top_sva (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic MUX_MODE,
    input wire logic [3:0] HOST_ADDR,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic [31:0] HOST_WDATA,
    input wire logic [31:0] HOST_RDATA,
    input wire logic [3:0] RXQ_POP,
    input wire logic [31:0] TXQ_DATA,
    input wire logic [3:0] TXQ_PUSH,
    input wire logic [1:0] HRQ_POP,
    input wire logic [31:0] HRQ0_HEAD
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    logic rd_sep;
    logic wr_sep;
    // only separate-address cycles can be decoded from the address pins
    assign rd_sep = HOST_RD && !MUX_MODE;
    assign wr_sep = HOST_WR && !MUX_MODE;
    a_rx_pop_select: assert property (rd_sep && HOST_ADDR < 4'h4 |=>
        RXQ_POP == 4'h1 << $past(HOST_ADDR[1:0])) else $error("wrong receive pop");
    a_tx_push_data: assert property (wr_sep && HOST_ADDR < 4'h4 |=>
        TXQ_PUSH == 4'h1 << $past(HOST_ADDR[1:0]) && TXQ_DATA == $past(HOST_WDATA)) else $error("bad push");
    a_pop_needs_read: assert property (RXQ_POP != 4'h0 |-> $past(HOST_RD)) else $error("pop without read");
    a_hrq_pop_select: assert property (rd_sep && HOST_ADDR[3:1] == 3'h3 |=>
        HRQ_POP == 2'h1 << $past(HOST_ADDR[0])) else $error("wrong host queue pop");
    a_head_load: assert property (wr_sep && HOST_ADDR == 4'h6 |=>
        HRQ0_HEAD == $past(HOST_WDATA)) else $error("head not loaded");
    a_rsvd_read_zero: assert property (rd_sep && HOST_ADDR[3:1] == 3'h2 |=>
        HOST_RDATA == 32'h0) else $error("reserved read not zero");
    a_upper_half_zero: assert property (rd_sep && HOST_ADDR[3] |=>
        HOST_RDATA[31:16] == 16'h0) else $error("upper half not zero");
    a_rdata_hold: assert property (!HOST_RD |=> $stable(HOST_RDATA)) else $error("read data moved");
endmodule : hri_top_sva
bind hri_top hri_top_sva i_hri_top_sva (.CLK(CLK), .RESET(RESET), .MUX_MODE(MUX_MODE), .HOST_ADDR(HOST_ADDR),
    .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .RXQ_POP(RXQ_POP),
    .TXQ_DATA(TXQ_DATA), .TXQ_PUSH(TXQ_PUSH), .HRQ_POP(HRQ_POP), .HRQ0_HEAD(HRQ0_HEAD));

// file: sim/tb_top.sv
// self-checking bench for the host register window
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, reset = 1'b1, strap = 1'b0, ale = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, txq_data, head0, head1, d, v;
    logic [3:0][31:0] rxq_data;
    logic [1:0][31:0] hrq_data;
    logic [3:0] rxq_pop, txq_push;
    logic [1:0] hrq_pop;
    logic mux_mode, irq_lo, irq_mid, irq_hi;
    logic [31:0] irq;
    hri_pkg::hri_events_t ev = '0;
    int n_errors = 0, total_checks = 0, dummy;
    logic [15:0] qc [6] = '{default: 16'h0};
    logic [15:0] b;
    logic [5:0] offs [9] = '{6'h20, 6'h24, 6'h28, 6'h30, 6'h2C, 6'h38, 6'h3C, 6'h10, 6'h14};
    assign irq = {29'h0, irq_hi, irq_mid, irq_lo}; // each line on its own host input
    always #12.5 clk = ~clk;
    hri_top i_hri_top (.CLK(clk), .RESET(reset), .BUS_MUX_SELECT(strap), .HOST_ALE(ale), .HOST_ADDR(addr),
        .HOST_RD(rd), .HOST_WR(wr), .HOST_WDATA(wdata), .HOST_RDATA(rdata), .RXQ_DATA(rxq_data),
        .RXQ_POP(rxq_pop), .TXQ_DATA(txq_data), .TXQ_PUSH(txq_push), .HRQ_DATA(hrq_data), .HRQ_POP(hrq_pop),
        .HRQ0_HEAD(head0), .HRQ1_HEAD(head1), .EVENTS(ev), .MUX_MODE(mux_mode), .IRQ_LINE_LOW(irq_lo),
        .IRQ_LINE_MID(irq_mid), .IRQ_LINE_HIGH(irq_hi));
    hri_core_model i_hri_core_model (.clk(clk), .rst(reset), .pop({hrq_pop, rxq_pop}), .rxq_data(rxq_data),
        .hrq_data(hrq_data));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // one host access; in mux mode the pins carry a wrong address on purpose
    task automatic acc(input logic w, input logic [5:0] off, input logic [31:0] wd);
        cyc(1);
        if (mux_mode) begin
            ale = 1'b1;
            wdata = {26'h0, off[5:2], 2'h0};
            cyc(1);
            ale = 1'b0;
        end
        addr = mux_mode ? ~off[5:2] : off[5:2];
        wdata = wd;
        rd = !w;
        wr = w;
        cyc(1);
        rd = 1'b0;
        wr = 1'b0;
        d = rdata;
    endtask : acc
    // one-cycle set pulse on one source, then time for the line to follow
    task automatic pulse(input int s, input logic [15:0] m);
        case (s)
            0: ev.queue_set = m;
            1: ev.timer_set = m;
            default: ev.io_set = m;
        endcase
        cyc(1);
        ev = '0;
        cyc(2);
    endtask : pulse
    function automatic logic [31:0] qword(input int q);
        return {8'h5A, 4'h0, 4'(q), qc[q]};
    endfunction : qword
    // hang guard
    initial begin
        cyc(20000);
        n_errors++;
        close_out();
    end
    initial begin
        dummy = $urandom(52550);
        cyc(20);
        reset = 1'b0;
        cyc(2);
        // writes to read-only and reserved places must leave no trace
        for (int i = 4; i < 9; i++) acc(1'b1, offs[i], $urandom);
        // combined bit 0 is already up: queue flags come out of reset nonzero
        for (int i = 0; i < 9; i++) begin
            acc(1'b0, offs[i], 32'h0);
            chk("reset value", d, i == 0 ? 32'h0F00 : (i == 4 ? 32'h1 : 32'h0));
        end
        // every queue read twice, then a push or head load
        for (int q = 0; q < 6; q++) begin
            repeat (2) begin
                acc(1'b0, q < 4 ? 6'(4 * q) : 6'(8 + 4 * q), 32'h0);
                chk("queue read", d, qword(q));
                qc[q]++;
            end
            v = $urandom;
            acc(1'b1, q < 4 ? 6'(4 * q) : 6'(8 + 4 * q), v);
            if (q < 4) begin
                chk("txq push", {28'h0, txq_push}, 32'h1 << q);
                chk("txq data", txq_data, v);
            end else begin
                chk("head", q == 4 ? head0 : head1, v);
            end
        end
        repeat (3) begin
            ev.txq_done = 2'b11;
            cyc(1);
            ev.txq_done = 2'b00;
            cyc(1);
        end
        acc(1'b0, 6'h3C, 32'h0);
        chk("done count", d, 32'h3);
        acc(1'b0, 6'h38, 32'h0);
        chk("done count 0", d, 32'h3);
        // a general indirect word survives a visit to another index
        v = $urandom;
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 6'h30, i == 1 ? 32'hA : 32'h9);
            if (i < 2) acc(1'b1, 6'h34, i == 0 ? v : ~v);
        end
        acc(1'b0, 6'h34, 32'h0);
        chk("indirect", d, {16'h0, v[15:0]});
        acc(1'b0, 6'h30, 32'h0);
        chk("index", d, 32'h9);
        acc(1'b1, 6'h20, 32'hFFFF);
        acc(1'b0, 6'h20, 32'h0);
        chk("queue clear", d, 32'h0);
        // every source routed to every line in turn
        for (int k = 0; k < 3; k++) begin
            for (int s = 0; s < 3; s++) begin
                b = 16'h1 << $urandom_range(7, 0);
                acc(1'b1, 6'h30, 32'(3 * k + s));
                acc(1'b1, 6'h34, {16'h0, b});
                pulse(s, b);
                chk("irq set", irq, 32'h1 << k);
                acc(1'b0, 6'h2C, 32'h0);
                chk("combined", d, 32'h1 << s);
                acc(1'b1, 6'(32 + 4 * s), {16'h0, b});
                cyc(1);
                chk("irq clear", irq, 32'h0);
                acc(1'b1, 6'h34, 32'h0);
            end
        end
        // two sources on the high line, never masked here: up until both cleared
        for (int i = 6; i < 8; i++) begin
            acc(1'b1, 6'h30, 32'(i));
            acc(1'b1, 6'h34, 32'h1);
            pulse(i - 6, 16'h1);
        end
        for (int i = 0; i < 2; i++) begin
            acc(1'b1, 6'(32 + 4 * i), 32'h1);
            cyc(1);
            chk("irq or", irq, i == 0 ? 32'h4 : 32'h0);
        end
        // second reset with the strap high: address travels on the data lines
        strap = 1'b1;
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        cyc(2);
        chk("mux mode", {31'h0, mux_mode}, 32'h1);
        acc(1'b0, 6'h20, 32'h0);
        chk("mux read", d, 32'h0F00);
        close_out();
    end
endmodule : tb_top
